/* hw/serial_link_rx_word_status.sv */
// Contract
// - Flag output serves as seventeenth data bit
// - Descramble flag when enhanced simplex enabled
// - Local mode times outputs by reference clock
// - Local mode launches outputs on reference rise
// - Data valid marks a sixteen bit data word
// - Control valid marks a fourteen bit control word
// - Flag output equals transmitted flag bit; held at 0 when flag-as-data is off
// - Ready after 64 error-free code fields
// - Simplex mode also checks flag toggling when flag-as-data is off
// - Ready drops on two consecutive code errors
// - Ready drops on missing flag toggle
// - Word error on any invalid encoding
// - Local mode: word, flag, valid, error, slip and ready outputs change on reference rise
// - Else outputs change on recovered clock fall
`default_nettype none
module serial_link_rx_word_status
  import rx_link_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [4:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              recovered_word_clock_i,
  input  wire logic              local_reference_clock_i,
  input  wire logic [WORD_W-1:0] coded_word_i,
  output logic      [15:0]       word_o,
  output logic                   received_flag_bit_o,
  output logic                   data_word_valid_o,
  output logic                   control_word_valid_o,
  output logic                   link_ready_o,
  output logic                   word_error_o,
  output logic                   word_slip_out_o,
  output logic                   recovered_word_clock_o,
  output logic                   recovered_word_clock_inverted_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // Word classification
  // ---------------------------------------------------------------
  function automatic word_kind_t classify(input logic [WORD_W-1:0] w);
    logic [3:0] c;
    c = w[WORD_W-1:PAY_W];
    if (c == CODE_DATA_F0 || c == CODE_DATA_F1)
      classify = KIND_DATA;
    else if (c == CODE_CTRL && w[PAY_W-1:CTRL_BITS] == 2'h0)
      classify = KIND_CTRL;
    else if (c == CODE_IDLE && w[PAY_W-1:0] == IDLE_PAYLOAD)
      classify = KIND_IDLE;
    else
      classify = KIND_BAD;
  endfunction

  function automatic logic code_ok(input logic [WORD_W-1:0] w);
    logic [3:0] c;
    c = w[WORD_W-1:PAY_W];
    code_ok = (c == CODE_DATA_F0) || (c == CODE_DATA_F1) ||
              (c == CODE_CTRL) || (c == CODE_IDLE);
  endfunction

  // ---------------------------------------------------------------
  // Synchronisers and edge detection
  // ---------------------------------------------------------------
  logic              rclk_s1_q, rclk_s2_q, rclk_s3_q;
  logic              ref_s1_q, ref_s2_q, ref_s3_q;
  logic [WORD_W-1:0] cw_s1_q, cw_s2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rclk_s1_q <= 1'b0;
      rclk_s2_q <= 1'b0;
      rclk_s3_q <= 1'b0;
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_s3_q  <= 1'b0;
      cw_s1_q   <= '0;
      cw_s2_q   <= '0;
    end else begin
      rclk_s1_q <= recovered_word_clock_i;
      rclk_s2_q <= rclk_s1_q;
      rclk_s3_q <= rclk_s2_q;
      ref_s1_q  <= local_reference_clock_i;
      ref_s2_q  <= ref_s1_q;
      ref_s3_q  <= ref_s2_q;
      cw_s1_q   <= coded_word_i;
      cw_s2_q   <= cw_s1_q;
    end
  end

  logic rclk_rise, rclk_fall, ref_rise;
  assign rclk_rise = rclk_s2_q & ~rclk_s3_q;
  assign rclk_fall = ~rclk_s2_q & rclk_s3_q;
  assign ref_rise  = ref_s2_q & ~ref_s3_q;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [2:0] ctrl_q;
  logic       fad, esmpx, lcs;
  assign fad   = ctrl_q[CTRL_FAD_BIT];
  assign esmpx = ctrl_q[CTRL_ESMPX_BIT];
  assign lcs   = ctrl_q[CTRL_LCS_BIT];

  logic wb_req, wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ctrl_q <= CTRL_RESET;
    else if (wb_wr && wb_adr_i == ADR_CTRL)
      ctrl_q <= wb_dat_i[2:0];
  end

  // ---------------------------------------------------------------
  // Capture and alignment qualification
  // ---------------------------------------------------------------
  logic              cap;
  logic [WORD_W-1:0] pend_word_q;
  logic              pend_q, slip_pend_q;
  logic              bad_prev_q, last_flag_q, have_last_q, ready_q;
  logic [7:0]        good_cnt_q;
  logic              cap_bad, cap_data, raw_flag, tog_bad;

  assign cap      = rclk_rise;
  assign cap_bad  = ~code_ok(cw_s2_q);
  assign cap_data = classify(cw_s2_q) == KIND_DATA;
  assign raw_flag = cw_s2_q[WORD_W-1:PAY_W] == CODE_DATA_F1;
  assign tog_bad  = esmpx & ~fad & cap_data & have_last_q &
                    (raw_flag == last_flag_q);

  logic launch;
  assign launch = lcs ? ref_rise : rclk_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_word_q <= '0;
      pend_q      <= 1'b0;
      slip_pend_q <= 1'b0;
    end else begin
      if (cap)
        pend_word_q <= cw_s2_q;
      pend_q      <= cap | (pend_q & ~launch);
      slip_pend_q <= (cap & pend_q & ~launch) | (slip_pend_q & ~launch);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bad_prev_q  <= 1'b0;
      last_flag_q <= 1'b0;
      have_last_q <= 1'b0;
      good_cnt_q  <= '0;
      ready_q     <= 1'b0;
    end else if (cap) begin
      bad_prev_q <= cap_bad;
      if (cap_data) begin
        last_flag_q <= raw_flag;
        have_last_q <= 1'b1;
      end
      if (cap_bad || tog_bad)
        good_cnt_q <= '0;
      else if (good_cnt_q != GOOD_RUN)
        good_cnt_q <= good_cnt_q + 8'h01;
      if ((cap_bad && bad_prev_q) || tog_bad)
        ready_q <= 1'b0;
      else if (!cap_bad && good_cnt_q == GOOD_RUN - 8'h01)
        ready_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Flag descrambling
  // ---------------------------------------------------------------
  logic tog_q;
  logic pend_data, pend_raw_flag, pend_flag;
  word_kind_t pend_kind;
  assign pend_kind     = classify(pend_word_q);
  assign pend_data     = pend_kind == KIND_DATA;
  assign pend_raw_flag = pend_word_q[WORD_W-1:PAY_W] == CODE_DATA_F1;
  assign pend_flag     = pend_raw_flag ^ (esmpx & tog_q);

  always_ff @(posedge clk_i) begin
    if (rst_i)
      tog_q <= 1'b0;
    else if (launch && pend_q && pend_data)
      tog_q <= ~tog_q;
  end

  // ---------------------------------------------------------------
  // Output launch
  // ---------------------------------------------------------------
  rx_out_t out_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= '0;
    end else if (launch) begin
      out_q.data  <= pend_kind == KIND_CTRL ?
                     {2'h0, pend_word_q[CTRL_BITS-1:0]} :
                     pend_word_q[PAY_W-1:0];
      out_q.flag  <= pend_q & pend_data & fad & pend_flag;
      out_q.dv    <= pend_q & (pend_kind == KIND_DATA);
      out_q.cv    <= pend_q & (pend_kind == KIND_CTRL);
      out_q.err   <= pend_q & (pend_kind == KIND_BAD);
      out_q.slip  <= slip_pend_q;
      out_q.ready <= ready_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recovered_word_clock_o          <= 1'b0;
      recovered_word_clock_inverted_o <= 1'b1;
    end else begin
      recovered_word_clock_o          <= rclk_s2_q;
      recovered_word_clock_inverted_o <= ~rclk_s2_q;
    end
  end

  assign word_o               = out_q.data;
  assign received_flag_bit_o  = out_q.flag;
  assign data_word_valid_o    = out_q.dv;
  assign control_word_valid_o = out_q.cv;
  assign link_ready_o         = out_q.ready;
  assign word_error_o         = out_q.err;
  assign word_slip_out_o      = out_q.slip;

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [IRQ_N-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic             rdy_out_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      rdy_out_prev_q <= 1'b0;
    else
      rdy_out_prev_q <= out_q.ready;
  end

  always_comb begin
    irq_set             = '0;
    irq_set[IRQ_RDY_UP] = out_q.ready & ~rdy_out_prev_q;
    irq_set[IRQ_RDY_DN] = ~out_q.ready & rdy_out_prev_q;
    irq_set[IRQ_WERR]   = launch & pend_q & (pend_kind == KIND_BAD);
    irq_set[IRQ_SLIP]   = launch & slip_pend_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
      irq_o      <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == ADR_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~wb_dat_i[IRQ_N-1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
      if (wb_wr && wb_adr_i == ADR_IRQ_MASK)
        irq_mask_q <= wb_dat_i[IRQ_N-1:0];
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          ADR_CTRL:      wb_dat_o <= {29'h0, ctrl_q};
          ADR_STATUS:    wb_dat_o <= {27'h0, out_q.err, out_q.slip,
                                      out_q.ready, ready_q, pend_q};
          ADR_IRQ_STAT:  wb_dat_o <= {28'h0, irq_stat_q};
          ADR_IRQ_MASK:  wb_dat_o <= {28'h0, irq_mask_q};
          ADR_LAST_WORD: wb_dat_o <= {12'h0, out_q.cv, out_q.dv,
                                      out_q.flag, 1'b0, out_q.data};
          default:       wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_launch_kind(word_kind_t k);
    launch && pend_q && pend_kind == k;
  endsequence

  property p_excl;
    !(data_word_valid_o && control_word_valid_o);
  endproperty
  a_excl: assert property (p_excl)
    else $error("data and control valid together");

  property p_data_valid;
    s_launch_kind(KIND_DATA) |=> data_word_valid_o && !word_error_o;
  endproperty
  a_data_valid: assert property (p_data_valid)
    else $error("data word not flagged valid");

  property p_ctrl_valid;
    s_launch_kind(KIND_CTRL) |=> control_word_valid_o && word_o[15:14] == 2'h0;
  endproperty
  a_ctrl_valid: assert property (p_ctrl_valid)
    else $error("control word not flagged valid");

  property p_werr;
    s_launch_kind(KIND_BAD) |=> word_error_o && !data_word_valid_o;
  endproperty
  a_werr: assert property (p_werr)
    else $error("bad word not flagged");

  property p_two_bad;
    cap && cap_bad && bad_prev_q |=>
      !ready_q ##1 (!link_ready_o || !$past(launch));
  endproperty
  a_two_bad: assert property (p_two_bad)
    else $error("ready kept after two code errors");

  property p_tog_drop;
    cap && tog_bad |=> !ready_q;
  endproperty
  a_tog_drop: assert property (p_tog_drop)
    else $error("ready kept after missing toggle");

  property p_ready_run;
    $rose(ready_q) |-> $past(good_cnt_q) == GOOD_RUN - 8'h01;
  endproperty
  a_ready_run: assert property (p_ready_run)
    else $error("ready rose without full good run");

  property p_stable;
    !launch |=> $stable(out_q);
  endproperty
  a_stable: assert property (p_stable)
    else $error("outputs changed outside launch");

  property p_flag;
    launch && pend_q && pend_data |=>
      received_flag_bit_o == ($past(fad) &
        ($past(pend_raw_flag) ^ ($past(esmpx) & $past(tog_q))));
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag output mismatch");

  property p_clk_pair;
    recovered_word_clock_inverted_o == !recovered_word_clock_o;
  endproperty
  a_clk_pair: assert property (p_clk_pair)
    else $error("recovered clock pair not complementary");

endmodule
`default_nettype wire

/* hw/rx_link_pkg.sv */
`default_nettype none
package rx_link_pkg;
  // ---------------------------------------------------------------
  // Coded word layout
  // ---------------------------------------------------------------
  localparam int          CODE_W         = 4;
  localparam int          PAY_W          = 16;
  localparam int          WORD_W         = CODE_W + PAY_W;
  localparam int          CTRL_BITS      = 14;
  localparam logic [3:0]  CODE_DATA_F0   = 4'hB;
  localparam logic [3:0]  CODE_DATA_F1   = 4'h4;
  localparam logic [3:0]  CODE_CTRL      = 4'h3;
  localparam logic [3:0]  CODE_IDLE      = 4'hC;
  localparam logic [15:0] IDLE_PAYLOAD   = 16'hFF00;

  // ---------------------------------------------------------------
  // Link qualification
  // ---------------------------------------------------------------
  localparam logic [7:0]  GOOD_RUN       = 8'h40;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0]  ADR_CTRL       = 5'h00;
  localparam logic [4:0]  ADR_STATUS     = 5'h04;
  localparam logic [4:0]  ADR_IRQ_STAT   = 5'h08;
  localparam logic [4:0]  ADR_IRQ_MASK   = 5'h0C;
  localparam logic [4:0]  ADR_LAST_WORD  = 5'h10;
  localparam int          CTRL_FAD_BIT   = 0;
  localparam int          CTRL_ESMPX_BIT = 1;
  localparam int          CTRL_LCS_BIT   = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h2;
  localparam int          IRQ_N          = 4;
  localparam int          IRQ_RDY_UP     = 0;
  localparam int          IRQ_RDY_DN     = 1;
  localparam int          IRQ_WERR       = 2;
  localparam int          IRQ_SLIP       = 3;
  localparam logic [3:0]  IRQ_RESET      = 4'h0;

  // ---------------------------------------------------------------
  // Word kinds and output bundle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_IDLE = 2'b00,
    KIND_DATA = 2'b01,
    KIND_CTRL = 2'b10,
    KIND_BAD  = 2'b11
  } word_kind_t;

  typedef struct packed {
    logic [15:0] data;
    logic        flag;
    logic        dv;
    logic        cv;
    logic        err;
    logic        slip;
    logic        ready;
  } rx_out_t;
endpackage
`default_nettype wire

/* verification/tx_link_model.sv */
`default_nettype none
module tx_link_model
  import rx_link_pkg::*;
(
  input  wire word_kind_t        kind_i,
  input  wire logic [15:0]       pay_i,
  input  wire logic              flag_i,
  input  wire logic              fad_i,
  input  wire logic              esmpx_i,
  input  wire logic              stuck_i,
  output var  logic              wclk_o,
  output var  logic [WORD_W-1:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic              t_q    = 1'b0;
  logic              raw;
  logic [WORD_W-1:0] word_q = {CODE_IDLE, IDLE_PAYLOAD};

  assign word_o = word_q;

  // ---------------------------------------------------------------
  // Free running word clock, 160 ns
  // ---------------------------------------------------------------
  initial begin
    wclk_o = 1'b0;
    forever #80 wclk_o = ~wclk_o;
  end

  // ---------------------------------------------------------------
  // Word launch on falling edge
  // ---------------------------------------------------------------
  always @(negedge wclk_o) begin
    if (fad_i) begin
      raw = flag_i ^ (esmpx_i & t_q);
    end else begin
      raw = t_q & ~stuck_i;
    end
    case (kind_i)
      KIND_DATA: begin
        word_q <= {raw ? CODE_DATA_F1 : CODE_DATA_F0, pay_i};
        t_q    <= ~t_q;
      end
      KIND_CTRL: word_q <= {CODE_CTRL, 2'b00, pay_i[13:0]};
      KIND_IDLE: word_q <= {CODE_IDLE, IDLE_PAYLOAD};
      default:   word_q <= {4'h0, pay_i};
    endcase
  end
endmodule
`default_nettype wire

/* verification/tb_serial_link_rx_word_status.sv */
`default_nettype none
module tb_serial_link_rx_word_status
  import rx_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] rdat;
  logic [19:0] cw;
  logic [15:0] word;
  logic [15:0] pay      = 16'h0000;
  logic [2:0]  rc       = 3'h0;
  logic        ack, wclk, flag, dv, cv, rdy, err, slip, wco, wcn, irq;
  logic        ref_clk  = 1'b0;
  logic        ref_run  = 1'b1;
  logic        tflag    = 1'b0;
  logic        fad      = 1'b0;
  logic        esmpx    = 1'b1;
  logic        stuck    = 1'b0;
  word_kind_t  kind     = KIND_IDLE;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  serial_link_rx_word_status serial_link_rx_word_status_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o(rdat),
    .wb_ack_o(ack), .recovered_word_clock_i(wclk),
    .local_reference_clock_i(ref_clk), .coded_word_i(cw),
    .word_o(word), .received_flag_bit_o(flag),
    .data_word_valid_o(dv), .control_word_valid_o(cv),
    .link_ready_o(rdy), .word_error_o(err), .word_slip_out_o(slip),
    .recovered_word_clock_o(wco),
    .recovered_word_clock_inverted_o(wcn), .irq_o(irq));

  tx_link_model tx_link_model_i (
    .kind_i(kind), .pay_i(pay), .flag_i(tflag), .fad_i(fad),
    .esmpx_i(esmpx), .stuck_i(stuck), .wclk_o(wclk), .word_o(cw));

  // ---------------------------------------------------------------
  // Clocks and timeout
  // ---------------------------------------------------------------
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    rc <= rc + 3'h1;
    if (ref_run) begin
      ref_clk <= rc[2];
    end
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    wb_cyc_i <= 1'b0;
    chk(32'(n), 32'h0000_0002);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic cfg(input logic f, input logic e, input logic l);
    wr(ADR_CTRL, {29'h0, l, e, f});
    fad   <= f;
    esmpx <= e;
  endtask
  task automatic settle();
    @(negedge wclk);
    tick(6);
  endtask
  task automatic send(input word_kind_t k, input logic [15:0] p,
                      input logic f, input int n);
    @(posedge clk_i);
    kind  <= k;
    pay   <= p;
    tflag <= f;
    repeat (n) @(negedge wclk);
    @(posedge clk_i);
    kind <= KIND_IDLE;
    settle();
  endtask
  task automatic ref_at(input logic [2:0] v, input logic r);
    do @(posedge clk_i); while (rc !== v);
    ref_run <= r;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rdchk(ADR_CTRL, {29'h0, CTRL_RESET});
    rdchk(ADR_IRQ_MASK, 32'h0);
    rdchk(ADR_IRQ_STAT, 32'h0);
    wr(5'h14, 32'hFFFF_FFFF);
    rdchk(5'h14, 32'h0);
    tick(1);
    chk1(rdy, 1'b0);
    chk1(wcn, ~wco);
  endtask
  task automatic t_ready();
    int n;
    cfg(1'b0, 1'b1, 1'b0);
    for (n = 0; n < 3000 && rdy !== 1'b1; n++) @(posedge clk_i);
    send(KIND_BAD, 16'h1234, 1'b0, 1);
    chk1(err, 1'b1);
    chk1(rdy, 1'b1);
    send(KIND_BAD, 16'h1234, 1'b0, 2);
    chk1(rdy, 1'b0);
    send(KIND_DATA, 16'hA5A5, 1'b1, 62);
    chk1(rdy, 1'b0);
    chk1(flag, 1'b0);
    settle();
    chk1(rdy, 1'b1);
    stuck <= 1'b1;
    send(KIND_DATA, 16'h0F0F, 1'b0, 2);
    stuck <= 1'b0;
    chk1(rdy, 1'b0);
  endtask
  task automatic t_words();
    for (int e = 0; e < 2; e++) begin
      cfg(1'b1, e[0], 1'b0);
      for (int f = 0; f < 2; f++) begin
        send(KIND_DATA, 16'hC3A5 ^ 16'(f), f[0], 1);
        chk1(flag, f[0]);
        chk({16'h0, word}, {16'h0, 16'hC3A5 ^ 16'(f)});
        chk1(dv & ~cv, 1'b1);
      end
    end
    send(KIND_CTRL, 16'hFFFF, 1'b1, 1);
    chk({16'h0, word}, 32'h3FFF);
    chk1(cv & ~dv, 1'b1);
    send(KIND_IDLE, 16'h0, 1'b0, 1);
    chk1(dv | cv | err, 1'b0);
  endtask
  task automatic t_irq();
    logic [31:0] q;
    wr(ADR_IRQ_STAT, 32'hF);
    wr(ADR_IRQ_MASK, 32'h1 << IRQ_WERR);
    tick(2);
    chk1(irq, 1'b0);
    send(KIND_BAD, 16'h0, 1'b0, 1);
    tick(2);
    chk1(irq, 1'b1);
    wr(ADR_IRQ_STAT, 32'h1 << IRQ_WERR);
    tick(2);
    chk1(irq, 1'b0);
    wr(ADR_IRQ_MASK, 32'h0);
    send(KIND_BAD, 16'h0, 1'b0, 1);
    tick(2);
    chk1(irq, 1'b0);
    wb(1'b0, ADR_IRQ_STAT, 32'h0, q);
    chk(q & 32'h4, 32'h4);
  endtask
  task automatic t_local();
    logic [31:0] q;
    cfg(1'b1, 1'b0, 1'b1);
    tick(40);
    ref_at(3'd1, 1'b0);
    @(posedge clk_i);
    kind <= KIND_DATA;
    pay  <= 16'h1111;
    repeat (4) @(negedge wclk);
    tick(6);
    chk1(dv, 1'b0);
    ref_at(3'd3, 1'b1);
    ref_at(3'd5, 1'b0);
    tick(6);
    chk({16'h0, word}, 32'h1111);
    chk1(dv & slip, 1'b1);
    rdchk(ADR_LAST_WORD, 32'h0004_1111);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(q & 32'h18, 32'h08);
    wb(1'b0, ADR_IRQ_STAT, 32'h0, q);
    chk(q & 32'h8, 32'h8);
    kind <= KIND_IDLE;
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_ready();
    t_words();
    t_irq();
    t_local();
    end_of_test();
  end
endmodule
`default_nettype wire
